// *** rtl/uart_core_pkg.sv ***
// constants shared by the serial core, its controller and the register link
package uart_core_pkg;
   // device register addresses
   localparam logic [15:0] MODE_ADDR   = 16'hff50;
   localparam logic [15:0] TXB_ADDR    = 16'hff51;
   localparam logic [15:0] RXB_ADDR    = 16'hff52;
   localparam logic [15:0] ERR_ADDR    = 16'hff53;
   localparam logic [15:0] TXSTAT_ADDR = 16'hff55;
   // mode register fields
   localparam int          PWR_BIT  = 7;
   localparam int          TXE_BIT  = 6;
   localparam int          RXE_BIT  = 5;
   localparam int          PS_HI    = 4;
   localparam int          PS_LO    = 3;
   localparam int          CL_BIT   = 2;
   localparam int          SL_BIT   = 1;
   localparam int          ISRM_BIT = 0;
   // error and transmit status fields
   localparam int          PE_BIT   = 2;
   localparam int          FE_BIT   = 1;
   localparam int          OVE_BIT  = 0;
   localparam int          TXBF_BIT = 1;
   localparam int          TXSF_BIT = 0;
   // reset values
   localparam logic [7:0]  MODE_RST = 8'h01;
   localparam logic [7:0]  TXB_RST  = 8'hff;
   localparam logic [7:0]  RXB_RST  = 8'hff;
   localparam logic [7:0]  ERR_RST  = 8'h00;
   // parity modes
   localparam logic [1:0]  PAR_NONE = 2'h0;
   localparam logic [1:0]  PAR_ZERO = 2'h1;
   localparam logic [1:0]  PAR_ODD  = 2'h2;
   localparam logic [1:0]  PAR_EVEN = 2'h3;
   // timing: hclk cycles per base clock half, base clocks per bit
   localparam logic [3:0]  BASE_HALF = 4'h2;
   localparam logic [4:0]  BIT_BASE  = 5'h10;
   localparam logic [4:0]  BIT_MID   = 5'h07;
   localparam logic [1:0]  PWR_WAIT  = 2'h2;
   // controller register offsets on the system bus
   localparam logic [3:0]  CTL_ADDR_OFS  = 4'h0;
   localparam logic [3:0]  CTL_WDATA_OFS = 4'h4;
   localparam logic [3:0]  CTL_RD_OFS    = 4'h8;
   localparam logic [3:0]  CTL_STAT_OFS  = 4'hc;
   localparam int          ST_BUSY_BIT   = 0;
   localparam int          ST_REFUSE_BIT = 2;

   function automatic logic par_of(input logic [7:0] d, input logic len8,
                                   input logic [1:0] mode);
      logic x;
      x = ^(len8 ? d : {1'b0, d[6:0]});
      case (mode)
         PAR_ODD:  par_of = ~x;
         PAR_EVEN: par_of = x;
         default:  par_of = 1'b0;
      endcase
   endfunction : par_of
endpackage : uart_core_pkg

// *** rtl/serial_reg_if.sv ***
// register link between the serial core and its controller
interface serial_reg_if;
   logic        req_wr;
   logic        req_rd;
   logic [15:0] req_addr;
   logic [7:0]  req_wdata;
   logic        rsp_ack;
   logic [7:0]  rsp_rdata;
   modport dev (input req_wr, req_rd, req_addr, req_wdata, output rsp_ack, rsp_rdata);
   modport ctl (output req_wr, req_rd, req_addr, req_wdata, input rsp_ack, rsp_rdata);
endinterface : serial_reg_if

// *** rtl/async_serial_tx_rx_core.sv ***
// asynchronous serial transmitter/receiver core
// Functional notes
// - buffer write starts transmission when enabled
// - transmit buffer resets to all ones
// - buffer moves first at once, continuous at done pulse
// - transfers and shifting on base clock falling edge
// - software skips writes while buffer full
// - software never refreshes buffer while active
// - mode register resets to 01h
// - power off stops clock, clears internal state
// - power off: output high, input seen high
// - bit timing starts at third base clock
// - enable clear resets its own circuit
// - parity field selects none/zero/odd/even
// - zero parity never flags parity error
// - length bit selects seven or eight bits
// - stop bits one/two on transmit only
// - routing bit steers errors between interrupts
// - software powers before enabling, disables first
// - enabling with line low starts reception
// - software disables before changing frame format
// - error register read-only, cleared by read
// - parity mismatch sets parity error
// - missing stop bit sets framing error
// - overrun keeps buffer, discards new byte
module async_serial_tx_rx_core
   import uart_core_pkg::*;
(
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // register link
   serial_reg_if.dev link,
   // serial pins
   output wire logic serial_out_pin,
   input  wire logic serial_in_pin,
   // event pulses
   output wire logic transmit_done_irq,
   output wire logic receive_done_irq,
   output wire logic receive_error_irq
);
   typedef struct packed {
      logic [7:0]  mode;
      logic [7:0]  txb;
      logic        txbf;
      logic        tx_busy;
      logic [10:0] tx_sh;
      logic [3:0]  tx_left;
      logic [4:0]  tx_div;
      logic        txd;
      logic [3:0]  base_cnt;
      logic        base_clk;
      logic [1:0]  pwr_cnt;
      logic [2:0]  rx_sync;
      logic        rx_lvl;
      logic        rx_busy;
      logic [4:0]  rx_div;
      logic [3:0]  rx_idx;
      logic [9:0]  rx_sh;
      logic [7:0]  rxb;
      logic        rx_full;
      logic [2:0]  err;
      logic        tx_irq;
      logic        rx_irq;
      logic        er_irq;
      logic        ack;
      logic [7:0]  rdata;
   } core_s;

   localparam core_s CORE_RST = '{mode: MODE_RST, txb: TXB_RST, txd: 1'b1,
      rx_sync: 3'h7, rx_lvl: 1'b1, rxb: RXB_RST, default: '0};

   core_s s_reg;
   core_s s_next;

   function automatic logic [10:0] frame_of(input logic [7:0] d, input logic [7:0] m);
      logic [11:0] f;
      f = 12'hfff;
      f[0] = 1'b0;
      f[8:1] = m[CL_BIT] ? d : {1'b1, d[6:0]};
      if (m[PS_HI:PS_LO] != PAR_NONE) begin
         f[m[CL_BIT] ? 9 : 8] = par_of(d, m[CL_BIT], m[PS_HI:PS_LO]);
      end
      frame_of = f[11:1];
   endfunction : frame_of

   logic       pwr;
   logic       txe;
   logic       rxe;
   logic       fall;
   logic       rx_in;
   logic [3:0] tx_bits;
   logic [3:0] rx_last;
   logic [3:0] len;
   logic       has_par;
   logic [7:0] rx_data;
   logic       rx_pe;
   logic       rx_fe;
   logic       rx_ov;

   always_comb begin
      s_next = s_reg;
      s_next.tx_irq = 1'b0;
      s_next.rx_irq = 1'b0;
      s_next.er_irq = 1'b0;
      s_next.ack = 1'b0;
      pwr = s_reg.mode[PWR_BIT];
      txe = s_reg.mode[TXE_BIT];
      rxe = s_reg.mode[RXE_BIT];
      len = s_reg.mode[CL_BIT] ? 4'h8 : 4'h7;
      has_par = s_reg.mode[PS_HI:PS_LO] != PAR_NONE;
      tx_bits = len + {3'h0, has_par} + (s_reg.mode[SL_BIT] ? 4'h2 : 4'h1);
      rx_last = len + {3'h0, has_par} + 4'h1;
      rx_in = pwr ? s_reg.rx_lvl : 1'b1;
      rx_data = s_reg.mode[CL_BIT] ? s_reg.rx_sh[7:0] : {1'b0, s_reg.rx_sh[6:0]};
      rx_pe = 1'b0;
      rx_fe = 1'b0;
      rx_ov = 1'b0;
      // pin input: three stages, change taken once stages two and three agree
      s_next.rx_sync = {s_reg.rx_sync[1:0], serial_in_pin};
      if (s_reg.rx_sync[1] == s_reg.rx_sync[2]) begin
         s_next.rx_lvl = s_reg.rx_sync[2];
      end
      // base clock, held low while powered down
      fall = 1'b0;
      if (s_reg.base_cnt == BASE_HALF - 4'h1) begin
         s_next.base_cnt = 4'h0;
         s_next.base_clk = ~s_reg.base_clk;
         fall = s_reg.base_clk;
      end else begin
         s_next.base_cnt = s_reg.base_cnt + 4'h1;
      end
      if (fall && s_reg.pwr_cnt != PWR_WAIT) begin
         s_next.pwr_cnt = s_reg.pwr_cnt + 2'h1;
      end
      fall = fall && s_reg.pwr_cnt == PWR_WAIT;
      // register link
      if (link.req_wr) begin
         s_next.ack = 1'b1;
         case (link.req_addr)
            MODE_ADDR: s_next.mode = link.req_wdata;
            TXB_ADDR: begin
               s_next.txb = link.req_wdata;
               s_next.txbf = pwr && txe;
            end
            default: ;
         endcase
      end else if (link.req_rd) begin
         s_next.ack = 1'b1;
         case (link.req_addr)
            MODE_ADDR:   s_next.rdata = s_reg.mode;
            TXB_ADDR:    s_next.rdata = s_reg.txb;
            RXB_ADDR: begin
               s_next.rdata = s_reg.rxb;
               s_next.rx_full = 1'b0;
            end
            ERR_ADDR: begin
               s_next.rdata = {5'h00, s_reg.err};
               s_next.err = 3'h0;
            end
            TXSTAT_ADDR: s_next.rdata = {6'h00, s_reg.txbf, s_reg.tx_busy};
            default:     s_next.rdata = 8'h00;
         endcase
      end
      // transmitter, all steps on the base clock falling edge
      if (fall) begin
         if (!s_reg.tx_busy) begin
            if (s_reg.txbf) begin
               {s_next.tx_sh, s_next.txd} = {frame_of(s_reg.txb, s_reg.mode), 1'b0};
               s_next.txbf = 1'b0;
               s_next.tx_busy = 1'b1;
               s_next.tx_left = tx_bits;
               s_next.tx_div = 5'h00;
            end
         end else if (s_reg.tx_div != BIT_BASE - 5'h01) begin
            s_next.tx_div = s_reg.tx_div + 5'h01;
         end else begin
            s_next.tx_div = 5'h00;
            if (s_reg.tx_left != 4'h0) begin
               s_next.txd = s_reg.tx_sh[0];
               s_next.tx_sh = {1'b1, s_reg.tx_sh[10:1]};
               s_next.tx_left = s_reg.tx_left - 4'h1;
            end else begin
               s_next.tx_irq = 1'b1;
               if (s_reg.txbf) begin
                  // next frame moves in in the same cycle as the done pulse
                  {s_next.tx_sh, s_next.txd} = {frame_of(s_reg.txb, s_reg.mode), 1'b0};
                  s_next.txbf = 1'b0;
                  s_next.tx_left = tx_bits;
               end else begin
                  s_next.tx_busy = 1'b0;
                  s_next.txd = 1'b1;
               end
            end
         end
      end
      // receiver
      if (fall && rxe) begin
         if (!s_reg.rx_busy) begin
            if (!rx_in) begin
               s_next.rx_busy = 1'b1;
               s_next.rx_div = 5'h00;
               s_next.rx_idx = 4'h0;
            end
         end else if (s_reg.rx_div != BIT_MID) begin
            s_next.rx_div = (s_reg.rx_div == BIT_BASE - 5'h01) ? 5'h00 : s_reg.rx_div + 5'h01;
         end else begin
            s_next.rx_div = s_reg.rx_div + 5'h01;
            s_next.rx_idx = s_reg.rx_idx + 4'h1;
            if (s_reg.rx_idx == 4'h0) begin
               s_next.rx_busy = !rx_in;
            end else if (s_reg.rx_idx != rx_last) begin
               s_next.rx_sh[s_reg.rx_idx - 4'h1] = rx_in;
            end else begin
               // stop bit sampled: only the first one is checked
               s_next.rx_busy = 1'b0;
               rx_fe = !rx_in;
               rx_pe = s_reg.mode[PS_HI] &&
                  s_reg.rx_sh[len] != par_of(rx_data, s_reg.mode[CL_BIT], s_reg.mode[PS_HI:PS_LO]);
               rx_ov = s_next.rx_full;
               if (!rx_ov) begin
                  s_next.rxb = rx_data;
                  s_next.rx_full = 1'b1;
               end
               s_next.err = s_next.err | {rx_pe, rx_fe, rx_ov};
               if ((rx_pe || rx_fe || rx_ov) && !s_reg.mode[ISRM_BIT]) begin
                  s_next.er_irq = 1'b1;
               end else begin
                  s_next.rx_irq = 1'b1;
               end
            end
         end
      end
      if (!txe) begin
         s_next.txbf = 1'b0;
         s_next.tx_busy = 1'b0;
         s_next.txd = 1'b1;
      end
      if (!rxe) begin
         s_next.rx_busy = 1'b0;
      end
      if (!pwr) begin
         s_next.base_clk = 1'b0;
         s_next.base_cnt = 4'h0;
         s_next.pwr_cnt = 2'h0;
         s_next.txbf = 1'b0;
         s_next.tx_busy = 1'b0;
         s_next.txd = 1'b1;
         s_next.rx_busy = 1'b0;
         s_next.err = 3'h0;
         s_next.rxb = RXB_RST;
         s_next.rx_full = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= CORE_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign serial_out_pin = s_reg.txd;
   assign transmit_done_irq = s_reg.tx_irq;
   assign receive_done_irq = s_reg.rx_irq;
   assign receive_error_irq = s_reg.er_irq;
   assign link.rsp_ack = s_reg.ack;
   assign link.rsp_rdata = s_reg.rdata;
endmodule : async_serial_tx_rx_core

// *** rtl/serial_core_ctl.sv ***
// bus controller that drives the serial core register link from AHB-Lite
module serial_core_ctl
   import uart_core_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output wire logic        hreadyout,
   output wire logic        hresp,
   output wire logic [31:0] hrdata,
   // register link
   serial_reg_if.ctl        link
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_POLL = 3'b010,
      ST_WAIT = 3'b100
   } ctl_state_e;

   typedef struct packed {
      ctl_state_e  st;
      logic [15:0] dev_addr;
      logic [7:0]  wdata;
      logic [7:0]  rd_data;
      logic        refused;
      logic [7:0]  mode;
      logic [7:0]  last_txb;
      logic        is_rd;
      logic        dp_wr;
      logic [3:0]  dp_ofs;
      logic        req_wr;
      logic        req_rd;
      logic [15:0] req_addr;
      logic [7:0]  req_wdata;
      logic        rdy;
      logic [31:0] rdata;
   } ctl_s;

   localparam ctl_s CTL_RST = '{st: ST_IDLE, mode: MODE_RST, last_txb: TXB_RST,
      rdy: 1'b1, default: '0};

   ctl_s s_reg;
   ctl_s s_next;
   logic [7:0] nm;
   logic [7:0] cm;
   logic       bad;

   always_comb begin
      s_next = s_reg;
      s_next.req_wr = 1'b0;
      s_next.req_rd = 1'b0;
      s_next.dp_wr = 1'b0;
      cm = s_reg.mode;
      nm = hwdata[7:0];
      bad = 1'b0;
      // address phase
      if (hsel && htrans[1] && hready) begin
         s_next.dp_wr = hwrite;
         s_next.dp_ofs = haddr[3:0];
         if (!hwrite) begin
            s_next.rdata = (haddr[3:0] == CTL_ADDR_OFS) ? {16'h0000, s_reg.dev_addr} :
               (haddr[3:0] == CTL_STAT_OFS) ? {16'h0000, s_reg.rd_data, 5'h00,
               s_reg.refused, 1'b0, s_reg.st != ST_IDLE} : 32'h0000_0000;
         end
      end
      // data phase of a write
      if (s_reg.dp_wr) begin
         if (s_reg.dp_ofs == CTL_ADDR_OFS) begin
            s_next.dev_addr = hwdata[15:0];
         end else if ((s_reg.dp_ofs == CTL_WDATA_OFS || s_reg.dp_ofs == CTL_RD_OFS)) begin
            if (s_reg.st != ST_IDLE) begin
               s_next.refused = 1'b1;
            end else if (s_reg.dp_ofs == CTL_RD_OFS) begin
               s_next.refused = 1'b0;
               s_next.is_rd = 1'b1;
               s_next.req_rd = 1'b1;
               s_next.req_addr = s_reg.dev_addr;
               s_next.st = ST_WAIT;
            end else begin
               if (s_reg.dev_addr == MODE_ADDR) begin
                  bad = ((nm[TXE_BIT] || nm[RXE_BIT]) && !cm[PWR_BIT]) ||
                     (!nm[PWR_BIT] && (cm[TXE_BIT] || cm[RXE_BIT]));
                  bad = bad || ((cm[TXE_BIT] || cm[RXE_BIT]) &&
                     nm[PS_HI:CL_BIT] != cm[PS_HI:CL_BIT]);
                  bad = bad || (cm[TXE_BIT] && nm[SL_BIT] != cm[SL_BIT]);
                  bad = bad || (cm[RXE_BIT] && nm[ISRM_BIT] != cm[ISRM_BIT]);
               end
               if (s_reg.dev_addr == TXB_ADDR && nm == s_reg.last_txb &&
                   cm[PWR_BIT] && (cm[TXE_BIT] || cm[RXE_BIT])) begin
                  bad = 1'b1;
               end
               s_next.refused = bad;
               if (!bad) begin
                  s_next.is_rd = 1'b0;
                  s_next.wdata = nm;
                  if (s_reg.dev_addr == TXB_ADDR) begin
                     s_next.req_rd = 1'b1;
                     s_next.req_addr = TXSTAT_ADDR;
                     s_next.st = ST_POLL;
                  end else begin
                     s_next.req_wr = 1'b1;
                     s_next.req_addr = s_reg.dev_addr;
                     s_next.req_wdata = nm;
                     s_next.st = ST_WAIT;
                  end
               end
            end
         end
      end
      // link sequencing
      case (s_reg.st)
         ST_POLL: begin
            if (link.rsp_ack) begin
               if (link.rsp_rdata[TXBF_BIT]) begin
                  s_next.req_rd = 1'b1;
               end else begin
                  s_next.req_wr = 1'b1;
                  s_next.req_addr = TXB_ADDR;
                  s_next.req_wdata = s_reg.wdata;
                  s_next.st = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (link.rsp_ack) begin
               s_next.st = ST_IDLE;
               if (s_reg.is_rd) begin
                  s_next.rd_data = link.rsp_rdata;
               end else if (s_reg.req_addr == MODE_ADDR) begin
                  s_next.mode = s_reg.req_wdata;
               end else if (s_reg.req_addr == TXB_ADDR) begin
                  s_next.last_txb = s_reg.req_wdata;
               end
            end
         end
         ST_IDLE: ;
         default: s_next.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= CTL_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hreadyout = s_reg.rdy;
   assign hresp = 1'b0;
   assign hrdata = s_reg.rdata;
   assign link.req_wr = s_reg.req_wr;
   assign link.req_rd = s_reg.req_rd;
   assign link.req_addr = s_reg.req_addr;
   assign link.req_wdata = s_reg.req_wdata;
endmodule : serial_core_ctl

// *** verification/serial_link_sva.sv ***
// assertions on the register link between controller and serial core
module serial_link_sva
   import uart_core_pkg::*;
(
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // link signals
   input wire logic        req_wr,
   input wire logic        req_rd,
   input wire logic [15:0] req_addr,
   input wire logic [7:0]  req_wdata,
   input wire logic        rsp_ack,
   input wire logic [7:0]  rsp_rdata
);
   logic [7:0] mode_sh;
   logic [7:0] txb_sh;
   logic       rd_go;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // write wins when both strobes are up
   assign rd_go = req_rd && !req_wr;

   // shadows of what actually crossed the link
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_sh <= MODE_RST;
         txb_sh  <= TXB_RST;
      end else if (req_wr && req_addr == MODE_ADDR) begin
         mode_sh <= req_wdata;
      end else if (req_wr && req_addr == TXB_ADDR) begin
         txb_sh <= req_wdata;
      end
   end

   property p_mode_readback;
      rd_go && req_addr == MODE_ADDR |=> rsp_ack && rsp_rdata == mode_sh;
   endproperty
   a_mode_readback: assert property (p_mode_readback) else $error("mode readback wrong");
   property p_txb_readback;
      rd_go && req_addr == TXB_ADDR |-> ##1 (rsp_ack && rsp_rdata == txb_sh);
   endproperty
   a_txb_readback: assert property (p_txb_readback) else $error("tx buffer readback wrong");
   property p_err_upper;
      rsp_ack && $past(rd_go && req_addr == ERR_ADDR) |-> rsp_rdata[7:3] == 5'h00;
   endproperty
   a_err_upper: assert property (p_err_upper) else $error("error flags upper bits set");

   property p_err_off;
      rd_go && req_addr == ERR_ADDR && !mode_sh[PWR_BIT] && !mode_sh[RXE_BIT]
         |=> rsp_rdata == ERR_RST;
   endproperty
   a_err_off: assert property (p_err_off) else $error("error flags kept while off");

   property p_rxb_off;
      rd_go && req_addr == RXB_ADDR && !mode_sh[PWR_BIT] |=> rsp_rdata == RXB_RST;
   endproperty
   a_rxb_off: assert property (p_rxb_off) else $error("rx buffer kept while off");

   property p_txstat_idle;
      rd_go && req_addr == TXSTAT_ADDR && !mode_sh[TXE_BIT] |=> rsp_rdata == 8'h00;
   endproperty
   a_txstat_idle: assert property (p_txstat_idle) else $error("tx status with tx off");

   property p_rxb_len;
      rd_go && req_addr == RXB_ADDR && mode_sh[PWR_BIT] && !mode_sh[CL_BIT] |=> !rsp_rdata[7];
   endproperty
   a_rxb_len: assert property (p_rxb_len) else $error("seven bit byte has bit 7");

   property p_txb_taken;
      req_wr && req_addr == TXB_ADDR |=> rsp_ack ##1 !rsp_ack;
   endproperty
   a_txb_taken: assert property (p_txb_taken) else $error("tx buffer write not taken");
endmodule : serial_link_sva

// *** verification/testbench.sv ***
// self-checking bench: AHB-Lite side of the controller, serial pins of the core
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("FAIL %0t: got %0h, expected %0h", $time, (g), (e)); end end
module testbench
   import uart_core_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BT = BIT_BASE * 2 * BASE_HALF;
   localparam logic [4:0] FMTS [4] = '{5'h04, 5'h0f, 5'h10, 5'h1b};
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        rx_line = 1'b1;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   wire logic        hreadyout, hresp, serial_out_pin, tx_done, rx_done, rx_err;
   wire logic [31:0] hrdata;
   int          mismatches, tests_run, cyc, tx_cnt, rxd_cnt, rxe_cnt;

   serial_reg_if link();
   async_serial_tx_rx_core u_async_serial_tx_rx_core (.hclk(hclk), .hresetn(hresetn),
      .link(link), .serial_out_pin(serial_out_pin), .serial_in_pin(rx_line),
      .transmit_done_irq(tx_done), .receive_done_irq(rx_done), .receive_error_irq(rx_err));
   serial_core_ctl u_serial_core_ctl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
   serial_link_sva u_serial_link_sva (.hclk(hclk), .hresetn(hresetn), .req_wr(link.req_wr),
      .req_rd(link.req_rd), .req_addr(link.req_addr), .req_wdata(link.req_wdata),
      .rsp_ack(link.rsp_ack), .rsp_rdata(link.rsp_rdata));

   always #2.5 hclk = ~hclk;
   always @(negedge hclk) begin
      cyc <= cyc + 1;
      tx_cnt <= tx_cnt + int'(tx_done === 1'b1);
      rxd_cnt <= rxd_cnt + int'(rx_done === 1'b1);
      rxe_cnt <= rxe_cnt + int'(rx_err === 1'b1);
   end

   task automatic tally_and_finish;
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : xfer

   // status polling; a tx buffer write may wait for the buffer to drain
   task automatic wait_idle(output logic [31:0] st);
      int n;
      n = 0;
      do begin
         xfer({28'h000_0000, CTL_STAT_OFS}, 1'b0, 32'h0000_0000, st);
         n++;
      end while (st[ST_BUSY_BIT] !== 1'b0 && n < 4000);
   endtask : wait_idle

   task automatic dev_wr(input logic [15:0] a, input logic [7:0] d, output logic [31:0] st);
      xfer({28'h000_0000, CTL_ADDR_OFS}, 1'b1, {16'h0000, a}, st);
      xfer({28'h000_0000, CTL_WDATA_OFS}, 1'b1, {24'h00_0000, d}, st);
      wait_idle(st);
   endtask : dev_wr

   task automatic dev_rd(input logic [15:0] a, output logic [7:0] d);
      logic [31:0] st;
      xfer({28'h000_0000, CTL_ADDR_OFS}, 1'b1, {16'h0000, a}, st);
      xfer({28'h000_0000, CTL_RD_OFS}, 1'b1, 32'h0000_0000, st);
      wait_idle(st);
      d = st[15:8];
   endtask : dev_rd

   function automatic logic exp_par(input logic [7:0] d, input int n, input logic [1:0] ps);
      logic x;
      x = ^(n == 8 ? d : {1'b0, d[6:0]});
      return (ps == PAR_ODD) ? ~x : ((ps == PAR_EVEN) ? x : 1'b0);
   endfunction : exp_par

   // start, data, parity, first stop; upper bits stay zero
   function automatic logic [10:0] exp_frame(input logic [7:0] d, input int n,
                                             input logic [1:0] ps);
      logic [10:0] v;
      int          hp;
      v = 11'h000;
      hp = int'(ps != PAR_NONE);
      for (int i = 0; i < n; i++) v[1+i] = d[i];
      if (hp == 1) v[1+n] = exp_par(d, n, ps);
      v[1+n+hp] = 1'b1;
      return v;
   endfunction : exp_frame

   task automatic tx_capture(input int nb, output logic [10:0] bits, output int gap);
      int t0;
      bits = 11'h000;
      @(negedge serial_out_pin);
      t0 = cyc;
      repeat (BT / 2) @(posedge hclk);
      for (int i = 0; i < nb; i++) begin
         if (i > 0) repeat (BT) @(posedge hclk);
         bits[i] = serial_out_pin;
      end
      @(negedge serial_out_pin);
      gap = cyc - t0;
   endtask : tx_capture

   // low stop bit held just past its mid sample
   task automatic send_frame(input logic [7:0] d, input int n, input int hp,
                             input logic pbit, input logic stop_lo);
      rx_line <= 1'b0;
      repeat (BT) @(posedge hclk);
      for (int i = 0; i < n + hp; i++) begin
         rx_line <= (i < n) ? d[i] : pbit;
         repeat (BT) @(posedge hclk);
      end
      rx_line <= ~stop_lo;
      repeat (40) @(posedge hclk);
      rx_line <= 1'b1;
      repeat (2 * BT) @(posedge hclk);
   endtask : send_frame

   initial begin
      repeat (60000) @(posedge hclk);
      $display("FAIL %0t: watchdog expired", $time);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      logic [31:0] st;
      logic [7:0]  v, cur, b0, b1, eb, msk;
      logic [4:0]  f;
      logic [1:0]  ps;
      logic [10:0] bits;
      int          n, hp, flen, gap, t0, r0, e0, ne;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      dev_rd(MODE_ADDR, v); `CHK(v, 8'h01)
      dev_rd(TXB_ADDR, v); `CHK(v, 8'hff)
      dev_rd(ERR_ADDR, v); `CHK(v, 8'h00)
      dev_rd(RXB_ADDR, v); `CHK(v, 8'hff)
      `CHK({hresp, serial_out_pin}, 2'b01)
      dev_wr(MODE_ADDR, 8'h40, st); `CHK(st[ST_REFUSE_BIT], 1'b1)
      dev_rd(MODE_ADDR, v); `CHK(v, 8'h01)
      cur = 8'h01;
      for (int k = 0; k < 4; k++) begin
         f = FMTS[k];
         ps = f[4:3];
         n = f[2] ? 8 : 7;
         msk = f[2] ? 8'hff : 8'h7f;
         hp = int'(ps != PAR_NONE);
         flen = 2 + n + hp + int'(f[1]);
         b0 = 8'ha6 ^ 8'(k);
         b1 = 8'h59 ^ 8'(k);
         dev_wr(MODE_ADDR, cur & 8'h9f, st);
         dev_wr(MODE_ADDR, {3'b100, f}, st);
         dev_wr(MODE_ADDR, {3'b111, f}, st);
         cur = {3'b111, f};
         t0 = tx_cnt;
         fork
            tx_capture(2 + n + hp, bits, gap);
            begin
               dev_wr(TXB_ADDR, b0, st);
               dev_wr(TXB_ADDR, b1, st);
            end
         join
         repeat (flen * BT + 16) @(posedge hclk);
         `CHK(bits, exp_frame(b0, n, ps))
         `CHK(gap >= flen * BT && gap <= flen * BT + 8, 1'b1)
         `CHK(tx_cnt - t0, 2)
         r0 = rxd_cnt;
         e0 = rxe_cnt;
         send_frame(b0, n, hp, exp_par(b0, n, ps), 1'b0);
         dev_rd(RXB_ADDR, v); `CHK(v, b0 & msk)
         dev_rd(ERR_ADDR, v); `CHK(v, 8'h00)
         send_frame(b1, n, hp, ~exp_par(b1, n, ps), ps == PAR_NONE);
         eb = (ps == PAR_NONE) ? 8'h01 << FE_BIT : ((ps == PAR_ZERO) ? 8'h00 : 8'h01 << PE_BIT);
         dev_rd(ERR_ADDR, v); `CHK(v, eb)
         dev_rd(ERR_ADDR, v); `CHK(v, 8'h00)
         dev_rd(RXB_ADDR, v);
         send_frame(b0, n, hp, exp_par(b0, n, ps), 1'b0);
         send_frame(b1, n, hp, exp_par(b1, n, ps), 1'b0);
         dev_rd(ERR_ADDR, v); `CHK(v, 8'h01 << OVE_BIT)
         dev_rd(RXB_ADDR, v); `CHK(v, b0 & msk)
         ne = int'(eb != 8'h00) + 1;
         `CHK(rxe_cnt - e0, f[0] ? 0 : ne)
         `CHK(rxd_cnt - r0, f[0] ? 4 : 4 - ne)
      end
      dev_wr(MODE_ADDR, cur ^ 8'h04, st); `CHK(st[ST_REFUSE_BIT], 1'b1)
      dev_wr(TXB_ADDR, 8'h3c, st);
      dev_wr(TXB_ADDR, 8'h3c, st); `CHK(st[ST_REFUSE_BIT], 1'b1)
      repeat (3 * BT) @(posedge hclk);
      dev_wr(MODE_ADDR, cur & 8'hbf, st);
      repeat (8) @(posedge hclk);
      `CHK(serial_out_pin, 1'b1)
      dev_rd(TXSTAT_ADDR, v); `CHK(v, 8'h00)
      dev_wr(MODE_ADDR, cur & 8'h9f, st);
      dev_wr(MODE_ADDR, 8'h84, st);
      rx_line <= 1'b0;
      dev_wr(MODE_ADDR, 8'ha4, st);
      repeat (9 * BT + 40) @(posedge hclk);
      rx_line <= 1'b1;
      repeat (2 * BT) @(posedge hclk);
      dev_rd(RXB_ADDR, v); `CHK(v, 8'h00)
      dev_rd(ERR_ADDR, v); `CHK(v, 8'h01 << FE_BIT)
      dev_wr(MODE_ADDR, 8'h84, st);
      dev_wr(MODE_ADDR, 8'h04, st);
      dev_rd(RXB_ADDR, v); `CHK(v, 8'hff)
      dev_rd(ERR_ADDR, v); `CHK(v, 8'h00)
      `CHK(serial_out_pin, 1'b1)
      tally_and_finish();
   end
endmodule : testbench
